// file: hdl/rxdq_defines.svh
// Constants for the receive descriptor queue DMA
// How it works
// - Nonzero head pointer write starts reception
// - Fill buffers in descriptor chain order
// - Last descriptor length becomes bytes stored
// - Set last fragment flag in last descriptor
// - Set queue tail flag on final packet
// - First descriptor gets flag and packet length
// - Clear hardware hw_owned_flag in first descriptor
// - Store last descriptor address as completion
// - Matching completion write drops interrupt
// - Descriptors chain through next link word
`ifndef RXDQ_DEFINES_SVH
`define RXDQ_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RXDQ_REG_HEAD 5'h00
`define RXDQ_REG_COMPL 5'h04
`define RXDQ_REG_INT_STAT 5'h08
`define RXDQ_REG_INT_EN 5'h0C
`define RXDQ_REG_INT_CLR 5'h10
`define RXDQ_REG_STATE 5'h14
// ----------------------------------------
// Descriptor word offsets and fields
// ----------------------------------------
`define RXDQ_DW_LINK 32'h0000_0000
`define RXDQ_DW_BUF 32'h0000_0004
`define RXDQ_DW_LEN 32'h0000_0008
`define RXDQ_DW_FLAGS 32'h0000_000C
`define RXDQ_OFF_LSB 16
`define RXDQ_FIRST_BIT 31
`define RXDQ_LAST_BIT 30
`define RXDQ_OWN_BIT 29
`define RXDQ_TAIL_BIT 28
`define RXDQ_OVERRUN_BIT 20
`define RXDQ_CRC_BIT 17
// ----------------------------------------
// Interrupt bits and reset values
// ----------------------------------------
`define RXDQ_INT_DONE 0
`define RXDQ_INT_OVR 1
`define RXDQ_RST_WORD 32'h0000_0000
`define RXDQ_RST_INT 2'h0
`define RXDQ_RST_LEN 11'h000
`endif

// file: hdl/rxdq_pkg.sv
// Types for the receive descriptor queue DMA
package rxdq_pkg;
  typedef enum logic [8:0] {
    RXDQ_IDLE = 9'h001,
    RXDQ_RD_LINK = 9'h002,
    RXDQ_RD_BUF = 9'h004,
    RXDQ_RD_LEN = 9'h008,
    RXDQ_DATA = 9'h010,
    RXDQ_WB_LEN = 9'h020,
    RXDQ_WB_LAST = 9'h040,
    RXDQ_WB_FIRST = 9'h080,
    RXDQ_DONE = 9'h100
  } rxdq_fsm_t;

  // One received byte from the switch port
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic err;
  } rxdq_beat_t;

  typedef struct packed {
    rxdq_fsm_t fsm;
    logic [31:0] head, compl, rdata, cur, first, link, bufp;
    logic [1:0] int_stat, int_en;
    logic ack;
    logic [10:0] boff, blen, cnt, pkt_len;
    logic err, ovr, drop, first_frag;
    logic mem_rd, mem_wr;
    logic [31:0] maddr, mwdata;
    logic [3:0] mbe;
  } rxdq_state_t;
endpackage : rxdq_pkg

// file: hdl/rxdq_dma.sv
// Receive descriptor queue DMA with Avalon-MM register slave and memory master
`timescale 1ns/10ps
`default_nettype none
`include "rxdq_defines.svh"
module rxdq_dma #(
  parameter int AV_AW = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [AV_AW-1:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  output logic [31:0] mem_address,
  output logic mem_read,
  output logic mem_write,
  output logic [31:0] mem_writedata,
  output logic [3:0] mem_byteenable,
  input wire logic [31:0] mem_readdata,
  input wire logic mem_waitrequest,
  input wire logic rx_valid,
  input wire rxdq_pkg::rxdq_beat_t rx_beat,
  output logic rx_ready,
  output logic irq
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (AV_AW < 5) begin : g_aw_chk
    $error("rxdq_dma: AV_AW must be at least 5");
  end

  rxdq_pkg::rxdq_state_t s;
  rxdq_pkg::rxdq_state_t next_s;
  logic mem_done;
  logic wr_en;
  logic [4:0] reg_addr;
  logic [31:0] byte_addr;
  logic [31:0] wb_flags;

  // ----------------------------------------
  // Output wiring
  // ----------------------------------------
  // Handshakes are combinational, data comes from the state register
  assign reg_addr = av_address[4:0];
  // With the clock enable low nothing is registered, so no access may complete
  assign av_waitrequest = (av_read | av_write) & ~(s.ack & ce);
  assign av_readdata = s.rdata;
  assign mem_address = s.maddr;
  assign mem_read = s.mem_rd;
  assign mem_write = s.mem_wr;
  assign mem_writedata = s.mwdata;
  assign mem_byteenable = s.mbe;
  // Memory cannot be held off; an access seen while frozen is simply repeated
  assign mem_done = (s.mem_rd | s.mem_wr) & ~mem_waitrequest;
  // A byte offered while frozen would be lost, so readiness follows the enable
  assign rx_ready = (s.fsm == rxdq_pkg::RXDQ_DATA) & ~s.mem_wr & ce;
  assign irq = |(s.int_stat & s.int_en);
  assign wr_en = av_write & s.ack;
  // Buffer start plus offset plus bytes already stored
  assign byte_addr = s.bufp + {21'h000000, s.boff} + {21'h000000, s.cnt};
  // Status word for the last descriptor; merged with the first when they coincide
  always_comb begin
    wb_flags = `RXDQ_RST_WORD;
    wb_flags[`RXDQ_LAST_BIT] = 1'b1;
    wb_flags[`RXDQ_TAIL_BIT] = (s.link == `RXDQ_RST_WORD);
    wb_flags[`RXDQ_OVERRUN_BIT] = s.ovr;
    wb_flags[`RXDQ_CRC_BIT] = s.err;
    if (s.first == s.cur) begin
      wb_flags[`RXDQ_FIRST_BIT] = 1'b1;
      wb_flags[10:0] = s.pkt_len;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_s = s;
    // Avalon slave: one wait cycle, then the access completes
    next_s.ack = (av_read | av_write) & ~s.ack;
    if ((av_read | av_write) & ~s.ack) begin
      case (reg_addr)
        `RXDQ_REG_HEAD: next_s.rdata = s.head;
        `RXDQ_REG_COMPL: next_s.rdata = s.compl;
        `RXDQ_REG_INT_STAT: next_s.rdata = {30'h00000000, s.int_stat};
        `RXDQ_REG_INT_EN: next_s.rdata = {30'h00000000, s.int_en};
        `RXDQ_REG_STATE: next_s.rdata = {s.cur[31:2], 1'b0, (s.fsm != rxdq_pkg::RXDQ_IDLE)};
        default: next_s.rdata = `RXDQ_RST_WORD;
      endcase
    end
    if (wr_en) begin
      case (reg_addr)
        `RXDQ_REG_HEAD: begin
          // Head is only taken while idle; a running queue is not disturbed
          if (s.fsm == rxdq_pkg::RXDQ_IDLE) next_s.head = av_writedata;
        end
        `RXDQ_REG_COMPL: begin
          // The pointer keeps the device's address, so a wrong acknowledge never clears
          if (av_writedata == s.compl) next_s.int_stat[`RXDQ_INT_DONE] = 1'b0;
        end
        `RXDQ_REG_INT_EN: next_s.int_en = av_writedata[1:0];
        `RXDQ_REG_INT_CLR: next_s.int_stat = s.int_stat & ~av_writedata[1:0];
        default: next_s.int_en = s.int_en;
      endcase
    end
    // Memory master request ends on the edge waitrequest is low
    if (mem_done) begin
      next_s.mem_rd = 1'b0;
      next_s.mem_wr = 1'b0;
    end
    case (s.fsm)
      rxdq_pkg::RXDQ_IDLE: begin
        if (s.head != `RXDQ_RST_WORD) begin
          next_s.cur = s.head;
          next_s.first = s.head;
          next_s.first_frag = 1'b1;
          next_s.pkt_len = `RXDQ_RST_LEN;
          next_s.err = 1'b0;
          next_s.ovr = 1'b0;
          next_s.drop = 1'b0;
          next_s.fsm = rxdq_pkg::RXDQ_RD_LINK;
        end
      end
      rxdq_pkg::RXDQ_RD_LINK: begin
        if (!s.mem_rd) begin
          next_s.mem_rd = 1'b1;
          next_s.maddr = s.cur + `RXDQ_DW_LINK;
        end else if (mem_done) begin
          next_s.link = mem_readdata;
          next_s.fsm = rxdq_pkg::RXDQ_RD_BUF;
        end
      end
      rxdq_pkg::RXDQ_RD_BUF: begin
        if (!s.mem_rd) begin
          next_s.mem_rd = 1'b1;
          next_s.maddr = s.cur + `RXDQ_DW_BUF;
        end else if (mem_done) begin
          next_s.bufp = mem_readdata;
          next_s.fsm = rxdq_pkg::RXDQ_RD_LEN;
        end
      end
      rxdq_pkg::RXDQ_RD_LEN: begin
        if (!s.mem_rd) begin
          next_s.mem_rd = 1'b1;
          next_s.maddr = s.cur + `RXDQ_DW_LEN;
        end else if (mem_done) begin
          next_s.boff = mem_readdata[`RXDQ_OFF_LSB+10:`RXDQ_OFF_LSB];
          next_s.blen = mem_readdata[10:0];
          next_s.cnt = `RXDQ_RST_LEN;
          next_s.fsm = rxdq_pkg::RXDQ_DATA;
        end
      end
      rxdq_pkg::RXDQ_DATA: begin
        if (!s.mem_wr && rx_valid) begin
          // Bytes land in order at the next free buffer position
          next_s.err = s.err | rx_beat.err;
          next_s.mwdata = {4{rx_beat.data}};
          next_s.maddr = {byte_addr[31:2], 2'b00};
          next_s.mbe = 4'h1 << byte_addr[1:0];
          next_s.mem_wr = ~s.drop;
          if (s.drop && rx_beat.last) next_s.fsm = rxdq_pkg::RXDQ_WB_LEN;
          if (!s.drop) next_s.pkt_len = s.pkt_len + 11'h001;
          // Remember the end of frame until the write is done
          next_s.mwdata[31:24] = rx_beat.data;
          next_s.first_frag = s.first_frag;
          next_s.drop = s.drop;
          next_s.ovr = s.ovr;
          next_s.link = s.link;
          next_s.boff = s.boff;
          next_s.blen = s.blen;
          next_s.bufp = s.bufp;
          next_s.cur = s.cur;
          next_s.first = s.first;
          next_s.head = next_s.head;
          next_s.mbe = rx_beat.last ? (next_s.mbe | 4'h0) : next_s.mbe;
          next_s.err = next_s.err;
          next_s.int_en = next_s.int_en;
          next_s.compl = next_s.compl;
          next_s.int_stat = next_s.int_stat;
          next_s.ack = next_s.ack;
          next_s.mem_rd = 1'b0;
          next_s.fsm = (s.drop && rx_beat.last) ? rxdq_pkg::RXDQ_WB_LEN : s.fsm;
          next_s.drop = s.drop;
          if (!s.drop) next_s.first_frag = rx_beat.last ? 1'b1 : 1'b0;
        end else if (mem_done) begin
          next_s.cnt = s.cnt + 11'h001;
          if (s.first_frag) begin
            next_s.fsm = rxdq_pkg::RXDQ_WB_LEN;
          end else if (s.cnt + 11'h001 >= s.blen) begin
            if (s.link == `RXDQ_RST_WORD) begin
              // Out of buffers: keep taking bytes but store none
              next_s.drop = 1'b1;
              next_s.ovr = 1'b1;
              next_s.int_stat[`RXDQ_INT_OVR] = 1'b1;
            end else begin
              next_s.cur = s.link;
              next_s.fsm = rxdq_pkg::RXDQ_RD_LINK;
            end
          end
        end
      end
      rxdq_pkg::RXDQ_WB_LEN: begin
        if (!s.mem_wr) begin
          next_s.mem_wr = 1'b1;
          next_s.mbe = 4'hF;
          next_s.maddr = s.cur + `RXDQ_DW_LEN;
          next_s.mwdata = {5'h00, s.boff, 5'h00, s.cnt};
        end else if (mem_done) begin
          next_s.fsm = rxdq_pkg::RXDQ_WB_LAST;
        end
      end
      rxdq_pkg::RXDQ_WB_LAST: begin
        if (!s.mem_wr) begin
          next_s.mem_wr = 1'b1;
          next_s.maddr = s.cur + `RXDQ_DW_FLAGS;
          next_s.mwdata = wb_flags;
        end else if (mem_done) begin
          next_s.fsm = (s.first == s.cur) ? rxdq_pkg::RXDQ_DONE : rxdq_pkg::RXDQ_WB_FIRST;
        end
      end
      rxdq_pkg::RXDQ_WB_FIRST: begin
        if (!s.mem_wr) begin
          next_s.mem_wr = 1'b1;
          next_s.maddr = s.first + `RXDQ_DW_FLAGS;
          // Hw_owned_flag bit left zero hands the buffers back
          next_s.mwdata = {1'b1, 20'h00000, s.pkt_len};
        end else if (mem_done) begin
          next_s.fsm = rxdq_pkg::RXDQ_DONE;
        end
      end
      rxdq_pkg::RXDQ_DONE: begin
        // Completion pointer and interrupt only after all write-backs
        next_s.compl = s.cur;
        next_s.int_stat[`RXDQ_INT_DONE] = 1'b1;
        next_s.head = (s.link == `RXDQ_RST_WORD || s.drop) ? `RXDQ_RST_WORD : s.link;
        next_s.fsm = rxdq_pkg::RXDQ_IDLE;
      end
      default: next_s.fsm = rxdq_pkg::RXDQ_IDLE;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes everything, bus handshake included
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.fsm <= rxdq_pkg::RXDQ_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  start_nonzero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s.fsm == rxdq_pkg::RXDQ_IDLE) ##1 (s.fsm == rxdq_pkg::RXDQ_RD_LINK)
      |-> $past(s.head) != `RXDQ_RST_WORD)
    else $error("reception started on zero head");
  data_order_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s.mem_wr) && s.fsm == rxdq_pkg::RXDQ_DATA
      |-> s.maddr[31:2] == byte_addr[31:2] && $onehot(s.mbe))
    else $error("data byte written out of order");
  last_len_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm == rxdq_pkg::RXDQ_WB_LEN
      |-> s.mwdata[10:0] == s.cnt && s.maddr == s.cur + `RXDQ_DW_LEN)
    else $error("last length word wrong");
  last_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm == rxdq_pkg::RXDQ_WB_LAST |-> s.mwdata[`RXDQ_LAST_BIT])
    else $error("last fragment flag missing");
  tail_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm == rxdq_pkg::RXDQ_WB_LAST
      |-> s.mwdata[`RXDQ_TAIL_BIT] == (s.link == `RXDQ_RST_WORD))
    else $error("queue tail flag wrong");
  first_word_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm == rxdq_pkg::RXDQ_WB_FIRST
      |-> s.mwdata[`RXDQ_FIRST_BIT] && s.mwdata[10:0] == s.pkt_len)
    else $error("first descriptor word wrong");
  owner_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && (s.fsm == rxdq_pkg::RXDQ_WB_FIRST || s.fsm == rxdq_pkg::RXDQ_WB_LAST)
      |-> !s.mwdata[`RXDQ_OWN_BIT])
    else $error("hw_owned_flag left set");
  completion_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && s.fsm == rxdq_pkg::RXDQ_DONE
      |=> s.compl == $past(s.cur) && s.int_stat[`RXDQ_INT_DONE])
    else $error("completion not posted");
  compl_match_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && wr_en && reg_addr == `RXDQ_REG_COMPL && av_writedata == s.compl
      && s.fsm != rxdq_pkg::RXDQ_DONE |=> !s.int_stat[`RXDQ_INT_DONE])
    else $error("matching completion write kept interrupt");
  link_chain_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && mem_done && s.fsm == rxdq_pkg::RXDQ_RD_LINK
      |=> s.link == $past(mem_readdata) && s.fsm == rxdq_pkg::RXDQ_RD_BUF)
    else $error("link word not followed");
  // Descriptor fetches walk the words of the current descriptor
  link_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_rd && s.fsm == rxdq_pkg::RXDQ_RD_LINK
      |-> s.maddr == s.cur + `RXDQ_DW_LINK)
    else $error("link word read from wrong address");
  buf_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_rd && s.fsm == rxdq_pkg::RXDQ_RD_BUF
      |-> s.maddr == s.cur + `RXDQ_DW_BUF)
    else $error("buffer word read from wrong address");
  len_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_rd && s.fsm == rxdq_pkg::RXDQ_RD_LEN
      |-> s.maddr == s.cur + `RXDQ_DW_LEN)
    else $error("length word read from wrong address");
  one_request_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(s.mem_rd && s.mem_wr))
    else $error("memory read and write at once");
  drop_no_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.drop && s.fsm == rxdq_pkg::RXDQ_DATA
      |-> !s.mem_wr)
    else $error("byte stored after buffers ran out");
  full_word_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm != rxdq_pkg::RXDQ_DATA
      |-> s.mbe == 4'hF)
    else $error("descriptor write not a full word");
  flag_merge_a: assert property (@(posedge clk) disable iff (!rst_b)
    s.mem_wr && s.fsm == rxdq_pkg::RXDQ_WB_LAST && s.first == s.cur
      |-> s.mwdata[`RXDQ_FIRST_BIT] && s.mwdata[10:0] == s.pkt_len)
    else $error("single descriptor lacks first flag");
  // The done interrupt may only follow the write-backs
  done_after_wb_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(s.int_stat[`RXDQ_INT_DONE])
      |-> $past(s.fsm) == rxdq_pkg::RXDQ_DONE)
    else $error("done interrupt before write-back");
  compl_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && wr_en && reg_addr == `RXDQ_REG_COMPL && av_writedata != s.compl
      && s.int_stat[`RXDQ_INT_DONE] |=> s.int_stat[`RXDQ_INT_DONE])
    else $error("differing completion write dropped interrupt");
  head_busy_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && wr_en && reg_addr == `RXDQ_REG_HEAD && s.fsm != rxdq_pkg::RXDQ_IDLE
      && s.fsm != rxdq_pkg::RXDQ_DONE |=> s.head == $past(s.head))
    else $error("head taken while busy");
  tail_head_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && s.fsm == rxdq_pkg::RXDQ_DONE && s.link == `RXDQ_RST_WORD
      |=> s.head == `RXDQ_RST_WORD)
    else $error("engine kept going past queue tail");
endmodule : rxdq_dma
`default_nettype wire

// file: testbench/rxdq_mem_model.sv
// Host memory model holding the descriptor chain and receive buffers
`timescale 1ns/10ps
`default_nettype none
module rxdq_mem_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);
  // ----------------------------------------
  // Storage: four-word descriptors linked by word 0
  // ----------------------------------------
  logic [31:0] mem [0:1023];
  logic [31:0] last_q = 32'h0000_0000;
  // Stalls come from the bench so slow answers are exercised
  assign waitrequest = stall;
  // Outside an answer the bus shows junk, never the last word
  assign readdata = (read && !stall) ? mem[address[11:2]] : ~last_q;
  // Writes land per byte lane at the accepting edge
  always @(posedge clk) begin
    if (read && !stall) begin
      last_q <= mem[address[11:2]];
    end
    if (write && !stall) begin
      for (int b = 0; b < 4; b++) begin
        if (byteenable[b]) begin
          mem[address[11:2]][8*b +: 8] <= writedata[8*b +: 8];
        end
      end
    end
  end
endmodule : rxdq_mem_model
`default_nettype wire

// file: testbench/rx_descriptor_queue_dma_bench.sv
// Self-checking bench for the receive descriptor queue DMA
`timescale 1ns/10ps
`default_nettype none
module rx_descriptor_queue_dma_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] av_address = 5'h00;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [31:0] av_writedata = 32'h0000_0000;
  logic [31:0] av_readdata, mem_address, mem_writedata, mem_readdata, rd;
  logic av_waitrequest, mem_read, mem_write, mem_waitrequest, rx_ready, irq;
  logic [3:0] mem_byteenable;
  logic rx_valid = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  rxdq_pkg::rxdq_beat_t rx_beat = '0;
  logic [31:0] seed = 32'h0000_2E00;
  logic [31:0] seed2 = 32'h0000_2E00;
  int failures = 0;
  int total_checks = 0;
  int q_addr[$];
  int q_byte[$];
  // ----------------------------------------
  // Clock, random memory stalls, instances
  // ----------------------------------------
  always #25 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Stalls use their own stream so byte values stay independent
  always @(posedge clk) begin
    seed2 <= xs(seed2);
    stall <= seed2[5];
    ce <= (seed2[12:11] != 2'b00); // Freeze about one cycle in four
  end
  rxdq_dma dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .av_address(av_address),
    .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .mem_address(mem_address),
    .mem_read(mem_read), .mem_write(mem_write), .mem_writedata(mem_writedata),
    .mem_byteenable(mem_byteenable), .mem_readdata(mem_readdata),
    .mem_waitrequest(mem_waitrequest), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .rx_ready(rx_ready), .irq(irq));
  rxdq_mem_model mem_u (.clk(clk), .stall(stall), .address(mem_address), .read(mem_read),
    .write(mem_write), .writedata(mem_writedata), .byteenable(mem_byteenable),
    .readdata(mem_readdata), .waitrequest(mem_waitrequest));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon access; the request holds until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge clk);
    av_address <= a;
    av_write <= wr;
    av_read <= ~wr;
    av_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (av_waitrequest !== 1'b0 && k < 100);
    q = av_readdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
    if (k >= 100) begin
      failures++;
      end_sim();
    end
  endtask : av
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rdchk
  // Offer a packet; expected byte addresses follow the buffer chain
  // Byte e carries a receive error; a1 of zero means bytes past cap are swallowed
  task automatic send(input int n, input int a0, input int cap, input int a1, input int e);
    int k;
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      b = seed[7:0];
      rx_beat <= {b, (i == n - 1), (i == e)};
      rx_valid <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (rx_ready !== 1'b1 && k < 2000);
      if (k >= 2000) begin
        failures++;
        end_sim();
      end
      if (i < cap || a1 != 0) begin
        q_addr.push_back(i < cap ? a0 + i : a1 + i - cap);
        q_byte.push_back(int'(b));
      end
      if (seed[9]) begin
        rx_valid <= 1'b0;
        @(posedge clk);
      end
    end
    rx_valid <= 1'b0;
  endtask : send
  task automatic check_bytes;
    int a;
    while (q_addr.size() > 0) begin
      a = q_addr.pop_front();
      chk({24'h000000, mem_u.mem[a >> 2][8*(a % 4) +: 8]}, 32'(q_byte.pop_front()));
    end
  endtask : check_bytes
  task automatic wait_irq(input logic lv);
    int k;
    k = 0;
    while (irq !== lv && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) begin
      failures++;
      end_sim();
    end
  endtask : wait_irq
  // ----------------------------------------
  // Main sequence: two-buffer packet, single-buffer tail packet, then overrun packet
  // ----------------------------------------
  initial begin
    mem_u.mem[64] = 32'h0000_0110;
    mem_u.mem[65] = 32'h0000_0200;
    mem_u.mem[66] = 32'h0001_0004;
    mem_u.mem[67] = 32'h2000_0000;
    mem_u.mem[68] = 32'h0000_0120;
    mem_u.mem[69] = 32'h0000_0300;
    mem_u.mem[70] = 32'h0000_0008;
    mem_u.mem[71] = 32'h2000_0000;
    mem_u.mem[72] = 32'h0000_0000;
    mem_u.mem[73] = 32'h0000_0400;
    mem_u.mem[74] = 32'h0000_0008;
    mem_u.mem[75] = 32'h2000_0000;
    mem_u.mem[76] = 32'h0000_0000;
    mem_u.mem[77] = 32'h0000_0500;
    mem_u.mem[78] = 32'h0000_0002;
    mem_u.mem[79] = 32'h2000_0000;
    mem_u.mem[320] = 32'h0000_0000;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    av(1'b1, 5'h00, 32'h0000_0000, rd);
    rdchk(5'h08, 32'h0000_0000);
    rdchk(5'h14, 32'h0000_0000);
    rdchk(5'h18, 32'h0000_0000);
    av(1'b1, 5'h0C, 32'h0000_0001, rd);
    av(1'b1, 5'h00, 32'h0000_0100, rd);
    send(6, 32'h201, 4, 32'h300, -1);
    wait_irq(1'b1);
    rdchk(5'h04, 32'h0000_0110);
    check_bytes();
    chk(mem_u.mem[70], 32'h0000_0002);
    chk(mem_u.mem[71] & 32'h5000_0000, 32'h4000_0000);
    chk(mem_u.mem[67], 32'h8000_0006);
    av(1'b1, 5'h04, 32'h0000_0ABC, rd);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    rdchk(5'h04, 32'h0000_0110);
    av(1'b1, 5'h04, 32'h0000_0110, rd);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    send(3, 32'h400, 8, 0, 1);
    wait_irq(1'b1);
    rdchk(5'h04, 32'h0000_0120);
    check_bytes();
    chk(mem_u.mem[74], 32'h0000_0003);
    chk(mem_u.mem[75], 32'hD002_0003);
    av(1'b1, 5'h0C, 32'h0000_0000, rd);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    rdchk(5'h08, 32'h0000_0001);
    av(1'b1, 5'h10, 32'h0000_0001, rd);
    rdchk(5'h08, 32'h0000_0000);
    rdchk(5'h00, 32'h0000_0000);
    av(1'b0, 5'h14, 32'h0000_0000, rd);
    chk(rd & 32'h0000_0001, 32'h0000_0000);
    // Packet longer than the only buffer: overrun, tail bytes swallowed
    av(1'b1, 5'h0C, 32'h0000_0001, rd);
    av(1'b1, 5'h00, 32'h0000_0130, rd);
    send(4, 32'h500, 2, 0, -1);
    wait_irq(1'b1);
    rdchk(5'h04, 32'h0000_0130);
    check_bytes();
    chk(mem_u.mem[320] & 32'hFFFF_0000, 32'h0000_0000);
    chk(mem_u.mem[79], 32'hD010_0002);
    rdchk(5'h08, 32'h0000_0003);
    end_sim();
  end
endmodule : rx_descriptor_queue_dma_bench
`default_nettype wire
